//--- hdl/fpk_pkg.sv
// shared constants, field layouts and carrier types of the flash protection block
package fpk_pkg;

	// ----------------------------------------------------------------
	// register byte offsets on the ahb-lite bus
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_INDEX  = 8'h04;
	localparam logic [7:0] ADDR_PROT   = 8'h08;
	localparam logic [7:0] ADDR_CCOB   = 8'h0c;
	localparam logic [7:0] ADDR_SEC    = 8'h10;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int STAT_COMPLETE = 7;
	localparam int STAT_VIOL     = 5;
	localparam int STAT_ACCERR   = 4;
	localparam int SEC_BACKDOOR_KEY_ENABLE_FIELD_LO  = 6;
	localparam int SEC_SECURED   = 0;
	localparam int INDEX_W       = 3;
	localparam int CCOB_W        = 16;
	localparam logic [7:0] PROT_FAULT_VALUE = 8'h7f;
	localparam logic [7:0] PROT_RESET_VALUE = 8'h7f;

	// ----------------------------------------------------------------
	// command object layout and command codes
	// ----------------------------------------------------------------
	localparam logic [2:0] CCOB_WORDS      = 3'h5;
	localparam logic [7:0] CMD_VERIFY_KEY  = 8'h0c;
	localparam logic [7:0] CMD_PROGRAM     = 8'h06;
	localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
	localparam logic [1:0] KEY_ENABLED     = 2'h2;

	// ----------------------------------------------------------------
	// flash address map
	// ----------------------------------------------------------------
	localparam logic [22:0] HIGH_TOP         = 23'h7f_ffff;
	localparam logic [22:0] LOW_BASE         = 23'h7f_8000;
	localparam logic [22:0] PROT_BYTE_ADDR   = 23'h7f_ff0c;
	localparam logic [22:0] REGION_UNIT_SIZE = 23'h00_0800;
	localparam logic [6:0]  BLOCK0_ID        = 7'h7f;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        popen;
		logic        reserved_nonvolatile_bit;
		logic        hdis;
		logic [1:0]  hs;
		logic        ldis;
		logic [1:0]  ls;
	} fpk_prot_t;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} fpk_ahb_req_t;

	typedef struct packed {
		logic [7:0]             protByte;
		logic                   doubleFault;
		logic [1:0]             keyEnable;
		logic                   secured;
		logic [3:0][CCOB_W-1:0] key;
	} fpk_nv_t;

	typedef enum logic [2:0] {
		ST_LOAD = 3'h1,
		ST_IDLE = 3'h2,
		ST_EXEC = 3'h4
	} fpk_state_t;

	typedef struct packed {
		fpk_state_t             state;
		fpk_prot_t              prot;
		logic                   secured;
		logic [1:0]             backdoor_key_enable_field;
		logic                   cmdDone;
		logic                   viol;
		logic                   accErr;
		logic [INDEX_W-1:0]     index;
		logic [4:0][CCOB_W-1:0] ccob;
		logic                   dpWrite;
		logic                   dpRead;
		logic [7:0]             dpAddr;
		logic                   hreadyout;
		logic                   hresp;
		logic [31:0]            hrdata;
	} fpk_regs_t;

	// size in bytes of a region for a two-bit size field
	function automatic logic [22:0] regionSize(input logic [1:0] sz);
		regionSize = REGION_UNIT_SIZE << sz;
	endfunction

endpackage

//--- hdl/fpk_region_check.sv
// decides whether an address or its whole block is protected
`timescale 1ns/100ps

module fpk_region_check (
	// protection setting
	input  wire fpk_pkg::fpk_prot_t prot,
	// global flash address under test
	input  wire logic [22:0]        addr,
	// verdicts
	output logic                    addrProtected,
	output logic                    blockProtected
);

	logic [22:0] hiStart;
	logic [22:0] loEnd;
	logic        inHigh;
	logic        inLow;
	logic        inBlock0;

	// region bounds: higher grows down from the top, lower grows up from its base
	assign hiStart  = 23'(fpk_pkg::HIGH_TOP - fpk_pkg::regionSize(prot.hs) + 23'h1);
	assign loEnd    = 23'(fpk_pkg::LOW_BASE + fpk_pkg::regionSize(prot.ls));
	assign inHigh   = !prot.hdis && (addr >= hiStart);
	assign inLow    = !prot.ldis && (addr >= fpk_pkg::LOW_BASE) && (addr < loEnd);
	assign inBlock0 = (addr[22:16] == fpk_pkg::BLOCK0_ID);

	// open regions are protected with popen set, unprotected with it clear
	assign addrProtected = prot.popen ? (inHigh || inLow) : !(inHigh || inLow);

	// every block is protected when popen is clear; with popen set block 0 is protected while a region is enabled
	assign blockProtected = prot.popen ? (inBlock0 && (!prot.hdis || !prot.ldis)) : 1'b1;

endmodule

//--- hdl/fpk_flash_protection.sv
// flash protection register, backdoor key command and ahb-lite register slave
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps

// How it works
// - key command needs enable field to unlock
// - matching four key words release security
// - protection writes may only enlarge protection
// - protection byte loaded after reset
// - double fault loads fully protected value
// - program into protected area flags violation
// - block erase refused if block protected
// - popen clear: regions are unprotected
// - popen set: regions are protected
// - higher region ends at flash top
// - higher size writable only while disabled
// - lower region starts at lower base
// - lower size writable only while disabled
// - command complete flag sets when done
module fpk_flash_protection (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// ahb-lite slave
	input  wire fpk_pkg::fpk_ahb_req_t ahbReq,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	// nonvolatile configuration field
	input  wire fpk_pkg::fpk_nv_t      nvConfig,
	// block status
	output logic                       securedState,
	output logic [7:0]                 protectionByte,
	output logic                       commandComplete
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	fpk_pkg::fpk_regs_t r;
	fpk_pkg::fpk_regs_t next_r;

	logic [31:0]        wdata;
	logic [7:0]         cmdCode;
	logic [22:0]        cmdAddr;
	logic               addrProtected;
	logic               blockProtected;
	logic               addrPhase;
	logic               keysMatch;
	fpk_pkg::fpk_prot_t protWrite;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------

	// a region set covers another when it is open and at least as large
	function automatic logic covers(
		input logic       bigOpen,
		input logic [1:0] bigSize,
		input logic       smallOpen,
		input logic [1:0] smallSize
	);
		covers = !smallOpen || (bigOpen && (bigSize >= smallSize));
	endfunction

	// true when the new setting protects everything the old one did
	function automatic logic protGrows(
		input fpk_pkg::fpk_prot_t oldP,
		input fpk_pkg::fpk_prot_t newP
	);
		logic ok;
		ok = 1'b0;
		case ({oldP.popen, newP.popen})
			// both list protected regions: each must stay or grow
			2'b11: begin
				ok = covers(!newP.hdis, newP.hs, !oldP.hdis, oldP.hs)
					&& covers(!newP.ldis, newP.ls, !oldP.ldis, oldP.ls);
			end
			// both list unprotected holes: each must stay or shrink
			2'b00: begin
				ok = covers(!oldP.hdis, oldP.hs, !newP.hdis, newP.hs)
					&& covers(!oldP.ldis, oldP.ls, !newP.ldis, newP.ls);
			end
			// holes of the new setting must miss the old protected regions
			2'b10: begin
				ok = !(!oldP.hdis && !newP.hdis) && !(!oldP.ldis && !newP.ldis);
			end
			// going from mostly protected to regions only always shrinks
			default: begin
				ok = 1'b0;
			end
		endcase
		protGrows = ok;
	endfunction

	// size fields only take the written value while their region is disabled
	function automatic fpk_pkg::fpk_prot_t mergeProt(
		input fpk_pkg::fpk_prot_t oldP,
		input logic [7:0]         wr
	);
		fpk_pkg::fpk_prot_t m;
		m       = fpk_pkg::fpk_prot_t'(wr);
		m.hs    = oldP.hdis ? m.hs : oldP.hs;
		m.ls    = oldP.ldis ? m.ls : oldP.ls;
		mergeProt = m;
	endfunction

	// register writes act only while no command is in flight
	function automatic logic writeOpen(input fpk_pkg::fpk_regs_t s);
		writeOpen = s.cmdDone && (s.state == fpk_pkg::ST_IDLE);
	endfunction

	// all four user key words must equal the stored words
	function automatic logic keyWordsMatch(
		input logic [4:0][fpk_pkg::CCOB_W-1:0] words,
		input logic [3:0][fpk_pkg::CCOB_W-1:0] stored
	);
		logic same;
		same = 1'b1;
		for (int k = 0; k < 4; k++) begin
			same = same && (words[k+1] == stored[k]);
		end
		keyWordsMatch = same;
	endfunction

	// read multiplexer over the register map
	function automatic logic [31:0] readWord(input fpk_pkg::fpk_regs_t s);
		logic [31:0] d;
		d = 32'h0;
		case (s.dpAddr)
			fpk_pkg::ADDR_STATUS: begin
				d[fpk_pkg::STAT_COMPLETE] = s.cmdDone;
				d[fpk_pkg::STAT_VIOL]     = s.viol;
				d[fpk_pkg::STAT_ACCERR]   = s.accErr;
			end
			fpk_pkg::ADDR_INDEX: begin
				d[fpk_pkg::INDEX_W-1:0] = s.index;
			end
			fpk_pkg::ADDR_PROT: begin
				d[7:0] = s.prot;
			end
			fpk_pkg::ADDR_CCOB: begin
				if (s.index < fpk_pkg::CCOB_WORDS) begin
					d[fpk_pkg::CCOB_W-1:0] = s.ccob[s.index];
				end
			end
			fpk_pkg::ADDR_SEC: begin
				d[fpk_pkg::SEC_BACKDOOR_KEY_ENABLE_FIELD_LO+:2] = s.backdoor_key_enable_field;
				d[fpk_pkg::SEC_SECURED]     = s.secured;
			end
			default: begin
				d = 32'h0;
			end
		endcase
		readWord = d;
	endfunction

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------

	// code in the high byte of word 0, address in words 1 and 2
	assign cmdCode   = r.ccob[0][15:8];
	assign cmdAddr   = {r.ccob[1][6:0], r.ccob[2]};
	assign wdata     = ahbReq.hwdata;
	assign protWrite = mergeProt(r.prot, wdata[7:0]);

	// user key words 0..3 sit at indices 1..4
	assign keysMatch = keyWordsMatch(r.ccob, nvConfig.key);

	// a transfer is taken when selected, nonsequential or sequential and the bus is ready
	assign addrPhase = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;

	// protection verdict for the commanded address
	fpk_region_check u_region (
		.prot           (r.prot),
		.addr           (cmdAddr),
		.addrProtected  (addrProtected),
		.blockProtected (blockProtected)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;

		// read data phase: present the word and release the bus
		next_r.dpWrite = 1'b0;
		if (r.dpRead) begin
			next_r.hrdata    = readWord(r);
			next_r.hreadyout = 1'b1;
			next_r.dpRead    = 1'b0;
		end

		// write data phase; writes are dropped while a command runs
		if (r.dpWrite && writeOpen(r)) begin
			case (r.dpAddr)
				// status: error flags clear by one, bit 7 launches
				fpk_pkg::ADDR_STATUS: begin
					if (wdata[fpk_pkg::STAT_VIOL]) begin
						next_r.viol = 1'b0;
					end
					if (wdata[fpk_pkg::STAT_ACCERR]) begin
						next_r.accErr = 1'b0;
					end
					if (wdata[fpk_pkg::STAT_COMPLETE]) begin
						next_r.cmdDone = 1'b0;
						next_r.state   = fpk_pkg::ST_EXEC;
					end
				end
				// command object index
				fpk_pkg::ADDR_INDEX: begin
					next_r.index = wdata[fpk_pkg::INDEX_W-1:0];
				end
				// protection: only changes that keep or enlarge it
				fpk_pkg::ADDR_PROT: begin
					if (protGrows(r.prot, protWrite)) begin
						next_r.prot = protWrite;
					end
				end
				// command object word at the current index
				fpk_pkg::ADDR_CCOB: begin
					if (r.index < fpk_pkg::CCOB_WORDS) begin
						next_r.ccob[r.index] = wdata[fpk_pkg::CCOB_W-1:0];
					end
				end
				default: begin
					next_r.dpWrite = 1'b0;
				end
			endcase
		end

		// address phase: reads stall one cycle, writes are zero-wait
		if (addrPhase) begin
			next_r.dpAddr = ahbReq.haddr[7:0];
			if (ahbReq.hwrite) begin
				next_r.dpWrite = 1'b1;
			end else begin
				next_r.dpRead    = 1'b1;
				next_r.hreadyout = 1'b0;
			end
		end

		// command sequencing
		case (r.state)
			// first cycle after reset: take the nonvolatile settings
			fpk_pkg::ST_LOAD: begin
				if (nvConfig.doubleFault) begin
					next_r.prot = fpk_pkg::fpk_prot_t'(fpk_pkg::PROT_FAULT_VALUE);
				end else begin
					next_r.prot = fpk_pkg::fpk_prot_t'(nvConfig.protByte);
				end
				next_r.secured = nvConfig.secured;
				next_r.backdoor_key_enable_field   = nvConfig.keyEnable;
				next_r.cmdDone = 1'b1;
				next_r.state   = fpk_pkg::ST_IDLE;
			end
			fpk_pkg::ST_IDLE: begin
				next_r.hresp = 1'b0;
			end
			// one-cycle execution; flags set here win over any clear
			fpk_pkg::ST_EXEC: begin
				case (cmdCode)
					// key check, gated by the enable field
					fpk_pkg::CMD_VERIFY_KEY: begin
						if (r.backdoor_key_enable_field != fpk_pkg::KEY_ENABLED) begin
							next_r.accErr = 1'b1;
						end else if (keysMatch) begin
							next_r.secured = 1'b0;
						end else begin
							next_r.secured = r.secured;
						end
					end
					// program only checks the target address
					fpk_pkg::CMD_PROGRAM: begin
						if (addrProtected) begin
							next_r.viol = 1'b1;
						end
					end
					// block erase needs the whole block open
					fpk_pkg::CMD_ERASE_BLOCK: begin
						if (blockProtected) begin
							next_r.viol = 1'b1;
						end
					end
					// unknown codes are access errors
					default: begin
						next_r.accErr = 1'b1;
					end
				endcase
				next_r.cmdDone = 1'b1;
				next_r.state   = fpk_pkg::ST_IDLE;
			end
			default: begin
				next_r.state = fpk_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------

	// reset leaves the array fully protected and secured until the load
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r.state     <= fpk_pkg::ST_LOAD;
			r.prot      <= fpk_pkg::fpk_prot_t'(fpk_pkg::PROT_RESET_VALUE);
			r.secured   <= 1'b1;
			r.backdoor_key_enable_field     <= 2'h0;
			r.cmdDone   <= 1'b0;
			r.viol      <= 1'b0;
			r.accErr    <= 1'b0;
			r.index     <= 3'h0;
			r.ccob      <= '0;
			r.dpWrite   <= 1'b0;
			r.dpRead    <= 1'b0;
			r.dpAddr    <= 8'h00;
			r.hreadyout <= 1'b1;
			r.hresp     <= 1'b0;
			r.hrdata    <= 32'h0;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------

	// every output is a field of the state register
	assign hreadyout       = r.hreadyout;
	assign hresp           = r.hresp;
	assign hrdata          = r.hrdata;
	assign securedState    = r.secured;
	assign protectionByte  = r.prot;
	assign commandComplete = r.cmdDone;

endmodule

//--- bench/fpk_flash_protection_props.sv
// concurrent checks on the ports of the flash protection block
`timescale 1ns/100ps
module fpk_flash_protection_props (
	// clock and reset
	input wire logic                  clk_sys,
	input wire logic                  rst_n,
	// bus and configuration
	input wire fpk_pkg::fpk_ahb_req_t ahbReq,
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	input wire logic [31:0]           hrdata,
	input wire fpk_pkg::fpk_nv_t      nvConfig,
	// status
	input wire logic                  securedState,
	input wire logic [7:0]            protectionByte,
	input wire logic                  commandComplete
);
	logic started;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// low only up to the load edge after reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			started <= 1'b0;
		end else begin
			started <= 1'b1;
		end
	end
	// steps of a read and of a command
	sequence s_readTaken;
		ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready && !ahbReq.hwrite;
	endsequence
	sequence s_readAnswer;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence s_execPulse;
		!commandComplete ##1 commandComplete;
	endsequence
	AST_OKAY: assert property (hresp == 1'b0) else $error("response not okay");
	AST_READ_WAIT: assert property (s_readTaken |=> s_readAnswer) else $error("read timing");
	AST_EXEC_ONE: assert property ($fell(commandComplete) |-> s_execPulse)
		else $error("command not completed in one cycle");
	AST_LOAD: assert property (!started |=> protectionByte == ($past(nvConfig.doubleFault) ?
		fpk_pkg::PROT_FAULT_VALUE : $past(nvConfig.protByte))) else $error("protection not loaded");
	AST_NO_POPEN_SET: assert property ($past(commandComplete) && !$past(protectionByte[7])
		|-> !protectionByte[7]) else $error("protection operation flipped to set");
	AST_HIGH_KEEP: assert property ($past(commandComplete) && $past(protectionByte[7]) &&
		protectionByte[7] |-> !$rose(protectionByte[5])) else $error("protected region dropped");
	AST_HS_LOCK: assert property ($past(commandComplete) && !$past(protectionByte[5])
		|-> $stable(protectionByte[4:3])) else $error("higher size changed while open");
	AST_LS_LOCK: assert property ($past(commandComplete) && !$past(protectionByte[2])
		|-> $stable(protectionByte[1:0])) else $error("lower size changed while open");
	AST_KEY_GATE: assert property ($past(started) && $fell(securedState) |-> !$past(commandComplete)
		&& $past(nvConfig.keyEnable) == fpk_pkg::KEY_ENABLED) else $error("unlock without key");
	AST_NO_RELOCK: assert property ($past(started) |-> !$rose(securedState))
		else $error("security set by a command");
endmodule

bind fpk_flash_protection fpk_flash_protection_props u_props (.clk_sys, .rst_n, .ahbReq,
	.hreadyout, .hresp, .hrdata, .nvConfig, .securedState, .protectionByte, .commandComplete);

//--- bench/fpk_cpu_model.sv
// cpu side model running single whole-word ahb-lite transfers
`timescale 1ns/100ps
module fpk_cpu_model (
	// clock
	input  wire logic            clk_sys,
	// slave answer
	input  wire logic            hreadyout,
	input  wire logic [31:0]     hrdata,
	input  wire logic            commandComplete,
	// request
	output fpk_pkg::fpk_ahb_req_t ahbReq
);
	fpk_pkg::fpk_ahb_req_t r = '0;
	// the one slave's ready is the bus ready
	always_comb begin
		ahbReq = r;
		ahbReq.hready = hreadyout;
	end
	// ready and data are taken at the rising edge that samples them
	task automatic waitRdy(output logic [31:0] q);
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	// entered just after a rising edge, returns at one
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		if (w) begin
			@(negedge clk_sys);
			while (commandComplete !== 1'b1) @(negedge clk_sys);
			@(posedge clk_sys);
		end
		r.hsel <= 1'b1;
		r.htrans <= 2'h2;
		r.hwrite <= w;
		r.hsize <= 3'h2;
		r.haddr <= {24'h0, a};
		waitRdy(q);
		r.hsel <= 1'b0;
		r.htrans <= 2'h0;
		r.hwdata <= d;
		waitRdy(q);
	endtask
endmodule

//--- bench/tb_top.sv
// self-checking bench of the flash protection block
`timescale 1ns/100ps
module tb_top;
	logic                  clk_sys = 1'b0;
	logic                  rst_n = 1'b0;
	fpk_pkg::fpk_ahb_req_t ahbReq;
	fpk_pkg::fpk_nv_t      nvConfig = '0;
	logic                  hreadyout, hresp, securedState, commandComplete, ke;
	logic [31:0]           hrdata, q;
	logic [7:0]            protectionByte, expP, wb, cand;
	logic [22:0]           fa;
	int                    seed = 32'hd679b5eb;
	int                    miscompares = 0, tests_run = 0, cycles = 0;

	fpk_flash_protection u_dut (.clk_sys, .rst_n, .ahbReq, .hreadyout, .hresp, .hrdata,
		.nvConfig, .securedState, .protectionByte, .commandComplete);
	fpk_cpu_model u_cpu (.clk_sys, .hreadyout, .hrdata, .commandComplete, .ahbReq);

	always #5 clk_sys = ~clk_sys;
	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 30000) begin
			miscompares++;
			wrap_up();
		end
	end
	// ----------------------------------------------------------------
	// expectations
	// ----------------------------------------------------------------
	function automatic logic grows(logic [7:0] o, logic [7:0] n);
		if (o[7] != n[7]) return o[7] && !((!o[5] && !n[5]) || (!o[2] && !n[2]));
		if (o[7]) return (o[5] || (!n[5] && n[4:3] >= o[4:3])) && (o[2] || (!n[2] && n[1:0] >= o[1:0]));
		return (n[5] || (!o[5] && n[4:3] <= o[4:3])) && (n[2] || (!o[2] && n[1:0] <= o[1:0]));
	endfunction
	function automatic logic addrProt(logic [7:0] p, logic [22:0] a);
		logic hi, lo;
		hi = !p[5] && {1'b0, a} > 24'h7f_ffff - (24'h800 << p[4:3]);
		lo = !p[2] && a >= 23'h7f_8000 && {1'b0, a} < 24'h7f_8000 + (24'h800 << p[1:0]);
		return p[7] ? (hi || lo) : !(hi || lo);
	endfunction
	// ----------------------------------------------------------------
	// bus, compare and closing tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_cpu.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		u_cpu.xfer(1'b0, a, 32'h0, q);
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// loads the command words, launches and polls for completion
	task automatic cmd(input logic [4:0][15:0] c);
		int n;
		n = 0;
		for (int j = 0; j < 5; j++) begin
			wr(fpk_pkg::ADDR_INDEX, 32'(j));
			wr(fpk_pkg::ADDR_CCOB, {16'h0, c[j]});
		end
		wr(fpk_pkg::ADDR_STATUS, 32'hb0);
		do rd(fpk_pkg::ADDR_STATUS); while (q[7] !== 1'b1 && ++n < 20);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence: per reset, load, writes, commands, key verify
	// ----------------------------------------------------------------
	initial begin
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			rst_n <= 1'b0;
			nvConfig <= {8'($random(seed)), i == 3, i[0], 1'b0, i != 2, $random(seed), $random(seed)};
			repeat (20) @(posedge clk_sys);
			rst_n <= 1'b1;
			repeat (2) @(posedge clk_sys);
			expP = nvConfig.doubleFault ? 8'h7f : nvConfig.protByte;
			chk("prot load", 32'(protectionByte), 32'(expP));
			rd(8'h20);
			chk("unmapped", q, 32'h0);
			chk("hresp", 32'(hresp), 32'h0);
			repeat (10) begin
				wb = 8'($random(seed));
				wb[7] = expP[7] ^ (wb[6:5] == 2'h3);
				wb[6] = expP[6];
				wr(fpk_pkg::ADDR_PROT, {24'h0, wb});
				cand = {wb[7:5], expP[5] ? wb[4:3] : expP[4:3], wb[2], expP[2] ? wb[1:0] : expP[1:0]};
				if (grows(expP, cand)) expP = cand;
				rd(fpk_pkg::ADDR_PROT);
				chk("prot reg", q, {24'h0, expP});
			end
			for (int k = 0; k < 4; k++) begin
				fa = {8'hff, 15'($random(seed))};
				if (k == 0) fa = fpk_pkg::HIGH_TOP;
				if (k == 3) fa = 23'h78_1234 ^ 23'($random(seed) & 32'hffff);
				cmd({32'h0, fa[15:0], 9'h0, fa[22:16], k[0] ? fpk_pkg::CMD_ERASE_BLOCK :
					fpk_pkg::CMD_PROGRAM, 8'h0});
				chk("status", {q[7], q[5], q[4]}, {1'b1, k[0] ? (!expP[7] || (fa[22:16] == 7'h7f
					&& !(expP[5] && expP[2]))) : addrProt(expP, fa), 1'b0});
			end
			cmd({64'h0, 8'h00, 8'h00});
			chk("unknown code", {q[7], q[5], q[4]}, 3'h5);
			chk("done pin", 32'(commandComplete), 32'h1);
			ke = nvConfig.keyEnable == fpk_pkg::KEY_ENABLED;
			cmd({nvConfig.key, fpk_pkg::CMD_VERIFY_KEY, 8'h0} ^ 80'h1_0000);
			chk("key mismatch", {securedState, q[4]}, {nvConfig.secured, !ke});
			cmd({nvConfig.key, fpk_pkg::CMD_VERIFY_KEY, 8'h0});
			rd(fpk_pkg::ADDR_SEC);
			chk("key match", {securedState, q[0], q[7:6]},
				{{2{nvConfig.secured && !ke}}, nvConfig.keyEnable});
		end
		wrap_up();
	end
endmodule
